// ==== trc_defs.svh ====
// Constants for the tag reader command controller.
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH
`define TRC_CLK_HZ 50000000
`define TRC_DIV(b) ((`TRC_CLK_HZ) / (b))
`define TRC_BAUD_DEF 9600
`define TRC_BAUD_00 2400
`define TRC_BAUD_01 9600
`define TRC_BAUD_10 19200
`define TRC_BAUD_11 57600
`define TRC_IND_MS 30
`define TRC_IND_CYC ((`TRC_CLK_HZ / 1000) * `TRC_IND_MS)
`define TRC_DB_MS 10
`define TRC_DB_CYC ((`TRC_CLK_HZ / 1000) * `TRC_DB_MS)
`define TRC_WMAX 16
`define TRC_A_CMD 4'h0
`define TRC_A_STAT 4'h4
`define TRC_A_TAGLO 4'h8
`define TRC_A_TAGHI 4'hc
`define TRC_C_READ 8'h52
`define TRC_C_STOP 8'h53
`define TRC_C_CONT 8'h43
`define TRC_C_CONT2 8'h4d
`define TRC_C_SING 8'h63
`define TRC_C_SING2 8'h6d
`define TRC_C_TOG 8'h78
`define TRC_C_SP 8'h20
`define TRC_C_BEEP 8'h42
`define TRC_C_NOBEEP 8'h62
`define TRC_C_QUIET 8'h51
`define TRC_C_LOUD 8'h71
`define TRC_C_CRLF 8'h3b
`define TRC_C_LFO 8'h3a
`define TRC_C_WRITE 8'h57
`define TRC_CR 8'h0d
`define TRC_LF 8'h0a
`endif

// ==== trc_pkg.sv ====
// Types for the tag reader command controller.
`default_nettype none
package trc_pkg;
  typedef enum logic [2:0] {RD_IDLE = 3'b001, RD_SCAN = 3'b010, RD_TRIG = 3'b100} trc_rd_type;
  typedef enum logic [4:0] {
    M_NONE = 5'b00001, M_RDY = 5'b00010, M_LOOK = 5'b00100, M_TAG = 5'b01000, M_NOID = 5'b10000
  } trc_msg_type;
  typedef struct packed {
    logic cont;
    logic beep;
    logic quiet;
    logic lf_only;
    logic led_en;
    logic disp_en;
  } trc_cfg_type;
  typedef struct packed {
    logic valid;
    logic [39:0] id;
  } trc_tag_type;
endpackage
`default_nettype wire

// ==== trc_uart_tx.sv ====
// Serial transmitter, 8 data bits, no parity, one stop bit.
`default_nettype none
module trc_uart_tx #(
  parameter int DW = 16
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic [DW-1:0] div, // clocks per bit
  input wire logic valid, // byte offered
  input wire logic [7:0] data, // byte
  output logic ready, // idle, byte taken
  output logic txd // serial out
);
  logic [9:0] sh_q;
  logic [3:0] n_q;
  logic [DW-1:0] c_q;
  assign ready = (n_q == 4'h0);
  assign txd = sh_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q <= 10'h3ff;
      n_q <= 4'h0;
      c_q <= '0;
    end else if (n_q == 4'h0) begin
      if (valid) begin
        sh_q <= {1'b1, data, 1'b0};
        n_q <= 4'ha;
        c_q <= div - 1'b1;
      end
    end else if (c_q == '0) begin
      sh_q <= {1'b1, sh_q[9:1]};
      n_q <= n_q - 1'b1;
      c_q <= div - 1'b1;
    end else begin
      c_q <= c_q - 1'b1;
    end
  end
endmodule // trc_uart_tx
`default_nettype wire

// ==== trc_uart_rx.sv ====
// Serial receiver, 8 data bits, no parity, one stop bit.
`default_nettype none
module trc_uart_rx #(
  parameter int DW = 16
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic [DW-1:0] div, // clocks per bit
  input wire logic rxd, // serial in, asynchronous
  output logic valid, // one-cycle byte pulse
  output logic [7:0] data // received byte
);
  logic s1_q, s2_q, v_q;
  logic [7:0] sh_q, d_q;
  logic [3:0] n_q;
  logic [DW-1:0] c_q;
  assign valid = v_q;
  assign data = d_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= rxd;
      s2_q <= s1_q;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_q <= 4'h0;
      c_q <= '0;
      sh_q <= 8'h00;
      d_q <= 8'h00;
      v_q <= 1'b0;
    end else begin
      v_q <= 1'b0;
      if (n_q == 4'h0) begin
        if (!s2_q) begin
          n_q <= 4'ha;
          c_q <= div >> 1;
        end
      end else if (c_q != '0) begin
        c_q <= c_q - 1'b1;
      end else if (n_q == 4'ha && s2_q) begin
        n_q <= 4'h0;
      end else if (n_q == 4'h1) begin
        v_q <= s2_q;
        d_q <= sh_q;
        n_q <= 4'h0;
      end else begin
        if (n_q != 4'ha) begin
          sh_q <= {s2_q, sh_q[7:1]};
        end
        n_q <= n_q - 1'b1;
        c_q <= div - 1'b1;
      end
    end
  end
endmodule // trc_uart_rx
`default_nettype wire

// ==== trc_ctrl.sv ====
// Tag reader serial command controller with trigger, indicator, display and register port.
// Operation
// - Serial link defaults to 9600 baud, 8 data bits, no parity, one stop.
// - Every outgoing message and tag line ends in carriage return, line feed; the code sends line feed alone once LF-only is selected.
// - Send ready prompt after power-on and looking prompt whenever scanning starts.
// - Single-character commands act at once; display write waits for its terminator.
// - Read command starts looking for tags; stop command ends looking.
// - Continuous-enable commands keep scanning after each found tag; indicator flashes per read.
// - Continuous-disable commands make scanning end after one valid tag or stop.
// - Space or toggle command switches between reading and stopped.
// - Beep-enable and beep-disable commands switch beeps and are stored.
// - Prompt-suppress stops prompts but not tag lines; matching command resumes; stored.
// - Two stored commands select CR plus LF or LF only terminators.
// - Every stored command writes its new setting to configuration memory.
// - Display write forwards up to 16 characters; seventeenth or control ends it.
// - Trigger asserted in continuous mode forces a single read.
// - Reading lasts as long as the trigger stays asserted.
// - Tag found under trigger stops antenna drive and sends the result.
// - Trigger released before a tag ends the read with no-identifier message.
// - Triggered results and no-tag messages go to serial port and display; under prompt-suppress the no-tag message skips the serial port.
// - New triggered read needs release and re-press, or the read command.
// - Read indicator idles high and goes low 30 ms per valid read.
// - Continuous switch selects continuous or single read at power-on.
// - Two baud switches select 2400, 9600, 19200 or 57600 at power-on.
// - Beep switch enables or disables the beeper at power-on.
// - LED switch enables or disables the read LED at power-on.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "trc_defs.svh"
`default_nettype none
module trc_ctrl import trc_pkg::*; #(
  parameter int IND_CYC = `TRC_IND_CYC,
  parameter int DB_CYC = `TRC_DB_CYC
) (
  input wire logic aclk, // clock, 50 MHz
  input wire logic aresetn, // sync reset
  input wire logic rxd, // serial in from host
  output logic txd, // serial out to host
  input wire logic trigger_n_in, // push-button, low pressed
  input wire trc_tag_type tag_in, // decoded tag from front end
  input wire logic continuous_default_switch, // power-on continuous
  input wire logic beep_default_switch, // power-on beep
  input wire logic baud_select_lo_switch, // baud select low
  input wire logic baud_select_hi_switch, // baud select high
  input wire logic display_present_switch, // display fitted
  input wire logic led_enable_switch, // power-on LED enable
  output logic antenna_on, // antenna drive
  output logic read_indicator_out, // read pulse, low active
  output logic led_out, // read LED
  output logic beep_out, // beep pulse
  output logic persist_wr, // configuration store pulse
  output trc_cfg_type persistent_setting, // configuration to store
  output logic disp_load, // display frame pulse
  output logic [127:0] disp_text, // display frame
  input wire logic [3:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI
  output logic awready, // AXI
  input wire logic [31:0] wdata, // AXI
  input wire logic [3:0] wstrb, // AXI
  input wire logic wvalid, // AXI
  output logic wready, // AXI
  output logic [1:0] bresp, // AXI
  output logic bvalid, // AXI
  input wire logic bready, // AXI
  input wire logic [3:0] araddr, // AXI read address
  input wire logic arvalid, // AXI
  output logic arready, // AXI
  output logic [31:0] rdata, // AXI
  output logic [1:0] rresp, // AXI
  output logic rvalid, // AXI
  input wire logic rready // AXI
);
  localparam int DBW = $clog2(DB_CYC);
  localparam int INW = $clog2(IND_CYC);
  localparam logic [39:0] S_RDY = "READY";
  localparam logic [55:0] S_LOOK = "LOOKING";
  localparam logic [87:0] S_NOID = "NO ID FOUND";
  logic [6:0] sy1_q, sy2_q;
  logic [1:0] por_q;
  logic running, trig_s, trig_q, flip, trig_rise, trig_fall;
  logic [DBW-1:0] db_cnt_q;
  trc_cfg_type cfg_q;
  logic [15:0] div_q;
  logic persist_wr_q, rx_v, tx_rdy, tx_v, fire, last, take, start, wflush;
  logic [7:0] rx_d, tx_ch, cmd_ch, bus_ch_q;
  logic cmd_v, bus_cmd_q, wmode_q;
  logic [4:0] wcnt_q, idx_q;
  logic [7:0] wbuf_q [`TRC_WMAX];
  trc_rd_type rd_q, rd_d;
  logic [3:0] pend_q, pset, pclr;
  trc_msg_type msg_q, nsel;
  logic [39:0] tag_q, mtag_q;
  logic ind_n_q, beep_q, dload_q;
  logic [INW-1:0] ind_cnt_q;
  logic [127:0] dtext_q, wframe;
  logic wr_go, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  function automatic logic [4:0] blen(trc_msg_type m);
    case (m)
      M_RDY: return 5'd5;
      M_LOOK: return 5'd7;
      M_TAG: return 5'd10;
      M_NOID: return 5'd11;
      default: return 5'd0;
    endcase
  endfunction

  function automatic logic [7:0] bch(trc_msg_type m, logic [4:0] i, logic [39:0] t);
    int j;
    logic [3:0] n;
    j = int'(i);
    n = t[4*(9-j) +: 4];
    case (m)
      M_RDY: return S_RDY[8*(4-j) +: 8];
      M_LOOK: return S_LOOK[8*(6-j) +: 8];
      M_NOID: return S_NOID[8*(10-j) +: 8];
      M_TAG: return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
      default: return 8'h20;
    endcase
  endfunction

  function automatic logic [127:0] frame(trc_msg_type m, logic [39:0] t);
    logic [127:0] f;
    f = '0;
    for (int k = 0; k < 16; k++) begin
      f[127-8*k -: 8] = (5'(k) < blen(m)) ? bch(m, 5'(k), t) : 8'h20;
    end
    return f;
  endfunction

  // Trigger and switch pins pass two flip-flops before any logic reads them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q <= 7'h40;
      sy2_q <= 7'h40;
    end else begin
      sy1_q <= {trigger_n_in, continuous_default_switch, beep_default_switch, baud_select_lo_switch,
                baud_select_hi_switch, display_present_switch, led_enable_switch};
      sy2_q <= sy1_q;
    end
  end
  assign trig_s = ~sy2_q[6];
  assign running = (por_q == 2'd3);

  // The pressed level must stay stable for the whole window before it is believed.
  assign flip = (trig_s != trig_q) && (db_cnt_q == DBW'(DB_CYC - 1));
  assign trig_rise = flip & trig_s;
  assign trig_fall = flip & ~trig_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      db_cnt_q <= '0;
      trig_q <= 1'b0;
    end else if (trig_s == trig_q) begin
      db_cnt_q <= '0;
    end else if (flip) begin
      trig_q <= trig_s;
      db_cnt_q <= '0;
    end else begin
      db_cnt_q <= db_cnt_q + 1'b1;
    end
  end

  assign cmd_v = running & (rx_v | bus_cmd_q);
  assign cmd_ch = rx_v ? rx_d : bus_ch_q;

  // Switches are caught once, on the third edge after reset release, when the synchronisers hold them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_q <= 2'd0;
      cfg_q <= '0;
      div_q <= 16'(`TRC_DIV(`TRC_BAUD_DEF));
      persist_wr_q <= 1'b0;
    end else begin
      persist_wr_q <= 1'b0;
      if (!running) begin
        por_q <= por_q + 2'd1;
      end
      if (por_q == 2'd2) begin
        cfg_q <= '{cont: sy2_q[5], beep: sy2_q[4], quiet: 1'b0, lf_only: 1'b0,
                   led_en: sy2_q[0], disp_en: sy2_q[1]};
        case ({sy2_q[2], sy2_q[3]})
          2'b00: div_q <= 16'(`TRC_DIV(`TRC_BAUD_00));
          2'b01: div_q <= 16'(`TRC_DIV(`TRC_BAUD_01));
          2'b10: div_q <= 16'(`TRC_DIV(`TRC_BAUD_10));
          default: div_q <= 16'(`TRC_DIV(`TRC_BAUD_11));
        endcase
      end else if (cmd_v && !wmode_q) begin
        case (cmd_ch)
          `TRC_C_CONT, `TRC_C_CONT2: cfg_q.cont <= 1'b1;
          `TRC_C_SING, `TRC_C_SING2: cfg_q.cont <= 1'b0;
          `TRC_C_BEEP, `TRC_C_NOBEEP: begin
            cfg_q.beep <= (cmd_ch == `TRC_C_BEEP);
            persist_wr_q <= 1'b1;
          end
          `TRC_C_QUIET, `TRC_C_LOUD: begin
            cfg_q.quiet <= (cmd_ch == `TRC_C_QUIET);
            persist_wr_q <= 1'b1;
          end
          `TRC_C_CRLF, `TRC_C_LFO: begin
            cfg_q.lf_only <= (cmd_ch == `TRC_C_LFO);
            persist_wr_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Display write gathers text and releases it at a control character or when a seventeenth character arrives.
  assign wflush = cmd_v & wmode_q & ((cmd_ch < 8'h20) | (wcnt_q == 5'(`TRC_WMAX)));
  always_comb begin
    wframe = '0;
    for (int k = 0; k < `TRC_WMAX; k++) begin
      wframe[127-8*k -: 8] = (5'(k) < wcnt_q) ? wbuf_q[k] : 8'h20;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wmode_q <= 1'b0;
      wcnt_q <= 5'd0;
      for (int k = 0; k < `TRC_WMAX; k++) begin
        wbuf_q[k] <= 8'h20;
      end
    end else if (cmd_v) begin
      if (!wmode_q && cmd_ch == `TRC_C_WRITE) begin
        wmode_q <= 1'b1;
        wcnt_q <= 5'd0;
      end else if (wflush) begin
        wmode_q <= 1'b0;
      end else if (wmode_q) begin
        wbuf_q[wcnt_q[3:0]] <= cmd_ch;
        wcnt_q <= wcnt_q + 5'd1;
      end
    end
  end

  // Read mode: commands come last so they override trigger and tag events, except that continuous-enable leaves a trigger start alone.
  always_comb begin
    rd_d = rd_q;
    pset = 4'b0000;
    take = 1'b0;
    if (por_q == 2'd2) begin
      rd_d = RD_SCAN;
      pset = 4'b0011;
    end
    if (running) begin
      case (rd_q)
        RD_IDLE: if (trig_rise) begin
          rd_d = RD_TRIG;
          pset[1] = 1'b1;
        end
        RD_SCAN: if (trig_rise) begin
          rd_d = RD_TRIG;
          pset[1] = 1'b1;
        end else if (tag_in.valid) begin
          take = 1'b1;
          pset[2] = 1'b1;
          if (!cfg_q.cont) begin
            rd_d = RD_IDLE;
          end
        end
        RD_TRIG: if (tag_in.valid) begin
          take = 1'b1;
          pset[2] = 1'b1;
          rd_d = RD_IDLE;
        end else if (trig_fall) begin
          rd_d = RD_IDLE;
          pset[3] = 1'b1;
        end
        default: rd_d = RD_IDLE;
      endcase
      if (cmd_v && !wmode_q) begin
        case (cmd_ch)
          `TRC_C_READ: begin
            rd_d = RD_SCAN;
            pset[1] = 1'b1;
          end
          `TRC_C_STOP: rd_d = RD_IDLE;
          `TRC_C_CONT, `TRC_C_CONT2: if (rd_d != RD_TRIG) begin
            rd_d = RD_SCAN;
            pset[1] = 1'b1;
          end
          `TRC_C_TOG, `TRC_C_SP: begin
            rd_d = (rd_q == RD_IDLE) ? RD_SCAN : RD_IDLE;
            pset[1] = (rd_q == RD_IDLE);
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    pclr = 4'b0000;
    nsel = M_NONE;
    if (msg_q == M_NONE) begin
      if (pend_q[0]) begin
        pclr[0] = 1'b1;
        nsel = M_RDY;
      end else if (pend_q[1]) begin
        pclr[1] = 1'b1;
        nsel = M_LOOK;
      end else if (pend_q[2]) begin
        pclr[2] = 1'b1;
        nsel = M_TAG;
      end else if (pend_q[3]) begin
        pclr[3] = 1'b1;
        nsel = M_NOID;
      end
    end
  end
  assign start = (nsel != M_NONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= RD_IDLE;
      pend_q <= 4'b0000;
      tag_q <= '0;
    end else begin
      rd_q <= rd_d;
      pend_q <= (pend_q & ~pclr) | pset;
      if (take) begin
        tag_q <= tag_in.id;
      end
    end
  end

  // Serial message sender; prompts are dropped when quiet but still reach the display.
  assign tx_v = (msg_q != M_NONE);
  assign fire = tx_v & tx_rdy;
  assign last = (idx_q == blen(msg_q) + 5'd1) || (cfg_q.lf_only && idx_q == blen(msg_q));
  always_comb begin
    if (idx_q < blen(msg_q)) begin
      tx_ch = bch(msg_q, idx_q, mtag_q);
    end else if (idx_q == blen(msg_q) && !cfg_q.lf_only) begin
      tx_ch = `TRC_CR;
    end else begin
      tx_ch = `TRC_LF;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_q <= M_NONE;
      idx_q <= 5'd0;
      mtag_q <= '0;
    end else if (fire) begin
      idx_q <= last ? 5'd0 : idx_q + 5'd1;
      if (last) begin
        msg_q <= M_NONE;
      end
    end else if (start) begin
      msg_q <= (cfg_q.quiet && nsel != M_TAG) ? M_NONE : nsel;
      idx_q <= 5'd0;
      mtag_q <= tag_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dload_q <= 1'b0;
      dtext_q <= '0;
      beep_q <= 1'b0;
    end else begin
      dload_q <= 1'b0;
      beep_q <= cfg_q.beep & (take | start);
      if (start && cfg_q.disp_en) begin
        dtext_q <= frame(nsel, tag_q);
        dload_q <= 1'b1;
      end else if (wflush && cfg_q.disp_en) begin
        dtext_q <= wframe;
        dload_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_n_q <= 1'b1;
      ind_cnt_q <= '0;
    end else if (take) begin
      ind_n_q <= 1'b0;
      ind_cnt_q <= INW'(IND_CYC - 1);
    end else if (ind_cnt_q != '0) begin
      ind_cnt_q <= ind_cnt_q - 1'b1;
    end else begin
      ind_n_q <= 1'b1;
    end
  end

  trc_uart_rx #(.DW(16)) u_rx (
    .aclk(aclk), .aresetn(aresetn), .div(div_q), .rxd(rxd), .valid(rx_v), .data(rx_d)
  );
  trc_uart_tx #(.DW(16)) u_tx (
    .aclk(aclk), .aresetn(aresetn), .div(div_q), .valid(tx_v), .data(tx_ch), .ready(tx_rdy), .txd(txd)
  );

  // Register slave; a bus command waits while a serial byte has the command path.
  assign wr_go = awvalid & wvalid & ~bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      bus_cmd_q <= 1'b0;
      bus_ch_q <= 8'h00;
    end else begin
      if (bus_cmd_q && running && !rx_v) begin
        bus_cmd_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr[1:0] == 2'b00) ? 2'b00 : 2'b11;
        if (awaddr == `TRC_A_CMD && wstrb[0]) begin
          bus_cmd_q <= 1'b1;
          bus_ch_q <= wdata[7:0];
        end
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= '0;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'b00;
      case (araddr)
        `TRC_A_CMD: rdata_q <= '0;
        `TRC_A_STAT: rdata_q <= {20'h00000, rd_q, tx_v, trig_q, wmode_q, cfg_q};
        `TRC_A_TAGLO: rdata_q <= tag_q[31:0];
        `TRC_A_TAGHI: rdata_q <= {24'h000000, tag_q[39:32]};
        default: begin
          rdata_q <= '0;
          rresp_q <= 2'b11;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign awready = wr_go;
  assign wready = wr_go;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign antenna_on = (rd_q != RD_IDLE);
  assign read_indicator_out = ind_n_q;
  assign led_out = cfg_q.led_en & ~ind_n_q;
  assign beep_out = beep_q;
  assign persist_wr = persist_wr_q;
  assign persistent_setting = cfg_q;
  assign disp_load = dload_q;
  assign disp_text = dtext_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ind_width: assert property ($fell(ind_n_q) |-> ind_cnt_q == INW'(IND_CYC - 1))
    else $error("indicator low time wrong");
  chk_ind_end: assert property (!ind_n_q && ind_cnt_q == '0 && !take |=> ind_n_q)
    else $error("indicator did not return high");
  chk_stop_cmd: assert property (cmd_v && !wmode_q && cmd_ch == `TRC_C_STOP |=> rd_q == RD_IDLE)
    else $error("stop command ignored");
  chk_read_cmd: assert property (cmd_v && !wmode_q && cmd_ch == `TRC_C_READ |=> rd_q == RD_SCAN && antenna_on)
    else $error("read command ignored");
  chk_trig_noid: assert property (rd_q == RD_TRIG && trig_fall && !tag_in.valid && !cmd_v
    |=> rd_q == RD_IDLE && (pend_q[3] || msg_q == M_NOID))
    else $error("no-id not raised on release");
  chk_trig_tag: assert property (rd_q == RD_TRIG && tag_in.valid && !cmd_v |=> !antenna_on && pend_q[2])
    else $error("triggered tag did not stop antenna");
  chk_cont_stay: assert property (rd_q == RD_SCAN && cfg_q.cont && tag_in.valid && !trig_rise && !cmd_v
    |=> rd_q == RD_SCAN)
    else $error("continuous read stopped");
  chk_single_stop: assert property (rd_q == RD_SCAN && !cfg_q.cont && tag_in.valid && !trig_rise && !cmd_v
    |=> rd_q == RD_IDLE)
    else $error("single read kept scanning");
  chk_cr_then_lf: assert property (fire && tx_ch == `TRC_CR |=> tx_v && tx_ch == `TRC_LF)
    else $error("carriage return not followed by line feed");
  chk_quiet_tx: assert property ($past(cfg_q.quiet) && $rose(tx_v) |-> msg_q == M_TAG)
    else $error("prompt sent while quiet");
  chk_trig_hold: assert property (rd_q == RD_TRIG && !trig_fall && !tag_in.valid && !cmd_v |=> rd_q == RD_TRIG)
    else $error("triggered read ended early");
  cov_trig_tag: cover property (rd_q == RD_TRIG && tag_in.valid);
  cov_trig_noid: cover property (rd_q == RD_TRIG ##1 rd_q == RD_IDLE && pend_q[3]);
  cov_wflush: cover property (wflush && disp_load == 1'b0 ##1 disp_load);
  cov_bus_cmd: cover property (wr_go && awaddr == `TRC_A_CMD);
endmodule // trc_ctrl
`default_nettype wire

// ==== trc_host.sv ====
// Host terminal model that sends and hears 8N1 serial frames.
`default_nettype none
module trc_host #(
  parameter int DIV = 868
) (
  input wire logic aclk, // clock
  output logic rxd, // to device
  input wire logic txd, // from device
  output logic [7:0] rx_byte, // first byte heard
  output logic rx_seen // first byte complete
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge aclk);
    end
  endtask
  initial begin
    logic [7:0] b;
    rxd = 1'b1;
    rx_seen = 1'b0;
    rx_byte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (DIV + DIV / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd;
        repeat (DIV) @(posedge aclk);
      end
      if (!rx_seen) rx_byte = b;
      rx_seen = 1'b1;
    end
  end
endmodule // trc_host
`default_nettype wire

// ==== trc_ctrl_bench.sv ====
// Self-checking bench for the tag reader command controller.
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module trc_ctrl_bench import trc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, trig_n = 1;
  logic rxd, txd, bvalid, arready, rvalid, awready, wready, antenna_on, read_indicator_out, seen, led, pw, dl;
  logic [3:0] awaddr = 0, araddr = 0, sw, ws = 4'hf;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [7:0] first;
  logic [15:0] s = 16'h0007;
  logic [7:0] cmds [10] = '{8'h53, 8'h52, 8'h78, 8'h51, 8'h3a, 8'h62, 8'h7a, 8'h57, 8'h41, 8'h0d};
  trc_tag_type tag_in = '0;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n, npw = 0, ndl = 0;
  trc_ctrl #(.IND_CYC(50), .DB_CYC(8)) u_trc_ctrl (.aclk, .aresetn, .rxd, .txd, .trigger_n_in(trig_n), .tag_in,
    .continuous_default_switch(sw[0]), .beep_default_switch(sw[1]), .baud_select_lo_switch(1'b1),
    .baud_select_hi_switch(1'b1), .display_present_switch(sw[2]), .led_enable_switch(sw[3]), .antenna_on,
    .read_indicator_out, .led_out(led), .beep_out(), .persist_wr(pw), .persistent_setting(), .disp_load(dl),
    .disp_text(), .awaddr, .awvalid, .awready, .wdata, .wstrb(ws), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  trc_host #(.DIV(868)) u_trc_host (.aclk, .rxd, .txd, .rx_byte(first), .rx_seen(seen));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Stored setting image: quiet, LF-only and beep-off commands applied when q is set.
  function automatic logic [5:0] st(input logic [3:0] w, input logic q);
    return {w[0], w[1] & ~q, q, q, w[3], w[2]};
  endfunction
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic trig(input logic v, input int k);
    @(posedge aclk);
    trig_n <= v;
    settle(k);
  endtask
  task automatic tag_pulse;
    s = lfsr(s);
    @(posedge aclk);
    tag_in <= {1'b1, s, s, s[7:0]};
    @(posedge aclk);
    tag_in.valid <= 1'b0;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] m);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    ws <= m;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #10 aclk = ~aclk;
  // Store and display strobes last one cycle, so they are counted where they are settled.
  always @(negedge aclk) begin
    npw += int'(pw === 1'b1);
    ndl += int'(dl === 1'b1);
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    s = lfsr(s);
    sw = s[3:0];
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(6);
    `CHK("indicator", 1'b1, read_indicator_out)
    `CHK("antenna", 1'b1, antenna_on)
    axr(4'h4);
    `CHK("status", st(sw, 1'b0), d[5:0])
    tag_pulse();
    @(negedge aclk);
    `CHK("led", sw[3], led)
    n = 1;
    do begin @(negedge aclk); n++; end while (read_indicator_out === 1'b0);
    `CHK("pulse", 51, n)
    `CHK("scan", sw[0], antenna_on)
    foreach (cmds[i]) begin
      axw(4'h0, {24'h0, cmds[i]}, 4'hf);
      settle(4);
      if (i < 3) `CHK("antenna", i == 1, antenna_on)
    end
    `CHK("store", 3, npw)
    `CHK("display", sw[2] ? 2 : 0, ndl)
    @(posedge aclk);
    u_trc_host.send(8'h20);
    settle(4);
    `CHK("serial", 1'b1, antenna_on)
    trig(1'b0, 3);
    trig(1'b1, 16);
    axr(4'h4);
    `CHK("status", st(sw, 1'b1), d[5:0])
    `CHK("bounce", 4'b0100, {d[11:9], d[7]})
    trig(1'b0, 16);
    axr(4'h4);
    `CHK("held", 4'b1001, {d[11:9], d[7]})
    tag_pulse();
    settle(4);
    `CHK("trig tag", 1'b0, antenna_on)
    axr(4'h8);
    `CHK("tag", {s[7:0], s, s[7:0]}, d)
    settle(16);
    `CHK("rearm", 1'b0, antenna_on)
    trig(1'b1, 16);
    axw(4'h0, 32'h52, 4'h0);
    settle(4);
    `CHK("strobe", 1'b0, antenna_on)
    trig(1'b0, 16);
    `CHK("repress", 1'b1, antenna_on)
    trig(1'b1, 16);
    `CHK("no id", 1'b0, antenna_on)
    axr(4'h2);
    `CHK("resp", 2'b11, r)
    while (seen !== 1'b1) @(posedge aclk);
    `CHK("prompt", 8'h52, first)
    end_sim();
  end
endmodule // trc_ctrl_bench
`default_nettype wire
